/* File: logic/irpm_top.sv */
// infrared pulse modulator with watchdog behind an AXI4-Lite slave
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module irpm_top #(
  parameter logic [16:0] WD_LIMIT = irpm_pkg::WD_LIMIT,
  parameter bit OPEN_DRAIN = 1'b1,
  parameter bit RESET_LOW = 1'b0
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic STOP_MODE_I,
  input wire irpm_pkg::irpm_axil_req_t S_AXI_I,
  output irpm_pkg::irpm_axil_rsp_t S_AXI_O,
  output logic IR_PULSE_OUT_O,
  output logic IR_PULSE_OE_O,
  output logic MODULATOR_IRQ_REQUEST_O,
  output logic WDOG_RESET_O
);

  typedef struct packed {
    irpm_pkg::irpm_state_t st;
    logic [7:0] on_time;
    logic [7:0] off_time;
    logic [7:0] pul_lo;
    logic [1:0] pul_hi;
    logic [9:0] cnt;
    logic [8:0] timer;
    logic cont;
    logic long_p;
    logic carrier;
    logic flag;
    logic wd_clr;
    logic aw_have;
    logic [irpm_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    irpm_pkg::irpm_axil_rsp_t rsp;
  } irpm_top_st_t;

  irpm_top_st_t s_q;
  irpm_top_st_t s_d;

  logic [irpm_pkg::WD_W-1:0] wd_count;
  logic wd_trip;
  logic do_write;
  logic start_req;
  logic do_start;
  logic clr_int;
  logic phase_end;
  logic finish;
  logic continuous;
  logic [4:0] wr_dec;
  logic [4:0] rd_dec;

  // returns {hit, index}; the low two bits are ignored, so an unaligned address hits its word
  function automatic logic [4:0] reg_decode(
    input logic [irpm_pkg::ADDR_W-1:0] a
  );
    logic [3:0] idx;
    idx = a[5:2];
    if (a[7:6] != 2'h0) begin
      reg_decode = {1'b0, idx};
    end else if (idx > irpm_pkg::IDX_LAST) begin
      reg_decode = {1'b0, idx};
    end else begin
      reg_decode = {1'b1, idx};
    end
  endfunction

  assign wr_dec = reg_decode(s_q.aw_addr);
  assign rd_dec = reg_decode(S_AXI_I.araddr);
  assign continuous = s_q.cont & !s_q.long_p;

  always_comb begin
    s_d = s_q;
    s_d.wd_clr = 1'b0;
    start_req = 1'b0;
    clr_int = 1'b0;
    phase_end = 1'b0;
    finish = 1'b0;
    do_write = s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid;

    // write address and data may arrive in either order
    if (s_q.rsp.awready && S_AXI_I.awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = S_AXI_I.awaddr;
      s_d.rsp.awready = 1'b0;
    end
    if (s_q.rsp.wready && S_AXI_I.wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = S_AXI_I.wdata[7:0];
      s_d.w_lane0 = S_AXI_I.wstrb[0];
      s_d.rsp.wready = 1'b0;
    end

    if (do_write) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = wr_dec[4] ? irpm_pkg::RESP_OKAY
                                : irpm_pkg::RESP_SLVERR;
      if (wr_dec[4] && s_q.w_lane0) begin
        if (wr_dec[3:0] == irpm_pkg::IDX_ON_TIME) begin
          s_d.on_time = s_q.w_data;
        end else if (wr_dec[3:0] == irpm_pkg::IDX_OFF_TIME) begin
          s_d.off_time = s_q.w_data;
        end else if (wr_dec[3:0] == irpm_pkg::IDX_PUL_LO) begin
          s_d.pul_lo = s_q.w_data;
          start_req = 1'b1;
        end else if (wr_dec[3:0] == irpm_pkg::IDX_CTRL) begin
          s_d.cont = s_q.w_data[irpm_pkg::CTRL_CONT_BIT];
          s_d.long_p = s_q.w_data[irpm_pkg::CTRL_LONG_BIT];
          s_d.carrier = s_q.w_data[irpm_pkg::CTRL_CARRIER_BIT];
          clr_int = s_q.w_data[irpm_pkg::CTRL_INTCLR_BIT];
          s_d.wd_clr = s_q.w_data[irpm_pkg::CTRL_WDCLR_BIT];
        end else if (wr_dec[3:0] == irpm_pkg::IDX_PUL_HI) begin
          s_d.pul_hi = s_q.w_data[1:0];
        end
      end
    end
    if (s_q.rsp.bvalid && S_AXI_I.bready) begin
      s_d.rsp.bvalid = 1'b0;
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready = 1'b1;
    end

    // read data is fixed at the address handshake
    if (s_q.rsp.arready && S_AXI_I.arvalid) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = rd_dec[4] ? irpm_pkg::RESP_OKAY
                                : irpm_pkg::RESP_SLVERR;
      s_d.rsp.rdata = '0;
      if (!rd_dec[4]) begin
        s_d.rsp.rdata = '0;
      end else if (rd_dec[3:0] == irpm_pkg::IDX_ON_TIME) begin
        s_d.rsp.rdata[7:0] = s_q.on_time;
      end else if (rd_dec[3:0] == irpm_pkg::IDX_OFF_TIME) begin
        s_d.rsp.rdata[7:0] = s_q.off_time;
      end else if (rd_dec[3:0] == irpm_pkg::IDX_PUL_LO) begin
        s_d.rsp.rdata[7:0] = s_q.cnt[7:0];
      end else if (rd_dec[3:0] == irpm_pkg::IDX_CTRL) begin
        // clear bits are write-only and read back as zero
        s_d.rsp.rdata[irpm_pkg::CTRL_CONT_BIT] = s_q.cont;
        s_d.rsp.rdata[irpm_pkg::CTRL_LONG_BIT] = s_q.long_p;
        s_d.rsp.rdata[irpm_pkg::CTRL_CARRIER_BIT] = s_q.carrier;
      end else if (rd_dec[3:0] == irpm_pkg::IDX_PUL_HI) begin
        s_d.rsp.rdata[1:0] = s_q.cnt[9:8];
      end else if (rd_dec[3:0] == irpm_pkg::IDX_STATUS) begin
        s_d.rsp.rdata[irpm_pkg::STAT_FLAG_BIT] = s_q.flag;
        s_d.rsp.rdata[irpm_pkg::STAT_BUSY_BIT] =
          (s_q.st != irpm_pkg::ST_IDLE);
      end else begin
        s_d.rsp.rdata[irpm_pkg::WD_W-1:0] = wd_count;
      end
    end
    if (s_q.rsp.rvalid && S_AXI_I.rready) begin
      s_d.rsp.rvalid = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // pulse sequencer; with the oscillator stopped the phases do not advance, but a start still loads
    if (!STOP_MODE_I) begin
      case (s_q.st)
        irpm_pkg::ST_ON: begin
          if (s_q.timer == '0) begin
            phase_end = 1'b1;
            if (!continuous) begin
              s_d.cnt = s_q.cnt - irpm_pkg::CNT_ONE;
            end
            if (!continuous && s_q.cnt == irpm_pkg::CNT_ONE) begin
              s_d.st = irpm_pkg::ST_IDLE;
              finish = 1'b1;
            end else if (s_q.long_p) begin
              // long pulse stays low across the whole count
              s_d.timer = {1'b0, s_q.on_time} + irpm_pkg::PHASE_EXTRA;
            end else begin
              s_d.st = irpm_pkg::ST_OFF;
              s_d.timer = {1'b0, s_q.off_time} + irpm_pkg::PHASE_EXTRA;
            end
          end else begin
            s_d.timer = s_q.timer - irpm_pkg::TIMER_ONE;
          end
        end
        irpm_pkg::ST_OFF: begin
          if (s_q.timer == '0) begin
            phase_end = 1'b1;
            s_d.st = irpm_pkg::ST_ON;
            s_d.timer = {1'b0, s_q.on_time} + irpm_pkg::PHASE_EXTRA;
          end else begin
            s_d.timer = s_q.timer - irpm_pkg::TIMER_ONE;
          end
        end
        default: begin
          s_d.st = irpm_pkg::ST_IDLE;
        end
      endcase
    end

    // the reload cycle and PHASE_EXTRA together make each phase last its value plus two
    do_start = start_req && !s_q.flag;
    if (do_start) begin
      s_d.st = irpm_pkg::ST_ON;
      s_d.timer = {1'b0, s_q.on_time} + irpm_pkg::PHASE_EXTRA;
      s_d.cnt = {s_q.pul_hi, s_q.w_data};
    end

    // a finishing train sets the flag even against a clear
    s_d.flag = (s_q.flag & !clr_int) | finish;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s_q.st <= irpm_pkg::ST_IDLE;
      s_q.on_time <= irpm_pkg::REG_RESET;
      s_q.off_time <= irpm_pkg::REG_RESET;
      s_q.pul_lo <= irpm_pkg::REG_RESET;
      s_q.pul_hi <= '0;
      s_q.cnt <= '0;
      s_q.timer <= '0;
      s_q.cont <= 1'b0;
      s_q.long_p <= 1'b0;
      s_q.carrier <= 1'b0;
      s_q.flag <= 1'b0;
      s_q.wd_clr <= 1'b0;
      s_q.aw_have <= 1'b0;
      s_q.aw_addr <= '0;
      s_q.w_have <= 1'b0;
      s_q.w_data <= '0;
      s_q.w_lane0 <= 1'b0;
      s_q.rsp <= '0;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  irpm_wdog #(
    .LIMIT(WD_LIMIT)
  ) u_wdog (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .clear_i(s_q.wd_clr),
    .halt_i(STOP_MODE_I),
    .count_o(wd_count),
    .trip_o(wd_trip)
  );

  // the pin stage registers the next phase so the pin moves with the state
  irpm_pin #(
    .OPEN_DRAIN(OPEN_DRAIN),
    .RESET_LOW(RESET_LOW)
  ) u_pin (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .active_i(s_d.st == irpm_pkg::ST_ON),
    .carrier_i(s_d.carrier),
    .pin_o(IR_PULSE_OUT_O),
    .oe_o(IR_PULSE_OE_O)
  );

  assign S_AXI_O = s_q.rsp;
  assign MODULATOR_IRQ_REQUEST_O = s_q.flag;
  assign WDOG_RESET_O = wd_trip;

  start_load_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    do_start |=> (s_q.st == irpm_pkg::ST_ON &&
      s_q.timer == {1'b0, s_q.on_time} + irpm_pkg::PHASE_EXTRA))
    else $error("start did not load on-time");

  timer_step_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (s_q.st != irpm_pkg::ST_IDLE && s_q.timer != '0 &&
     !STOP_MODE_I && !do_start)
    |=> s_q.timer == $past(s_q.timer) - irpm_pkg::TIMER_ONE)
    else $error("pulse timer did not step by one");

  on_to_off_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (phase_end && s_q.st == irpm_pkg::ST_ON && !s_q.long_p &&
     !continuous && s_q.cnt != irpm_pkg::CNT_ONE && !do_start)
    |=> (s_q.st == irpm_pkg::ST_OFF &&
      s_q.cnt == $past(s_q.cnt) - irpm_pkg::CNT_ONE &&
      s_q.timer == {1'b0, s_q.off_time} + irpm_pkg::PHASE_EXTRA))
    else $error("on phase end handled wrongly");

  off_to_on_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (phase_end && s_q.st == irpm_pkg::ST_OFF && !do_start)
    |=> (s_q.st == irpm_pkg::ST_ON &&
      s_q.timer == {1'b0, s_q.on_time} + irpm_pkg::PHASE_EXTRA))
    else $error("off phase end handled wrongly");

  finish_flag_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    finish |=> (s_q.flag && s_q.st == irpm_pkg::ST_IDLE &&
      MODULATOR_IRQ_REQUEST_O))
    else $error("train end did not raise flag");

  no_restart_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (s_q.flag && s_q.st == irpm_pkg::ST_IDLE && !clr_int)
    |=> s_q.st == irpm_pkg::ST_IDLE [*2])
    else $error("modulator restarted with flag set");

  set_wins_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (finish && clr_int) |=> s_q.flag)
    else $error("flag set lost to clear");

  endless_train_a: assert property (@(posedge CLOCK_I)
    disable iff (RST_I)
    (continuous && s_q.st != irpm_pkg::ST_IDLE && !do_start)
    |=> (s_q.cnt == $past(s_q.cnt) && s_q.st != irpm_pkg::ST_IDLE))
    else $error("continuous train used the count");

  long_pulse_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (phase_end && s_q.st == irpm_pkg::ST_ON && s_q.long_p &&
     s_q.cnt != irpm_pkg::CNT_ONE && !do_start)
    |=> s_q.st == irpm_pkg::ST_ON)
    else $error("long pulse left the on phase");

  // pin as seen from outside: a low line means the led is on
  start_pin_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (do_start && s_q.st == irpm_pkg::ST_IDLE)
    |=> (OPEN_DRAIN ? IR_PULSE_OE_O : !IR_PULSE_OUT_O))
    else $error("start did not drive the pin active");

  finish_pin_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (finish && !do_start)
    |=> (OPEN_DRAIN ? !IR_PULSE_OE_O : IR_PULSE_OUT_O))
    else $error("pin still active after train end");

  idle_hold_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (s_q.st == irpm_pkg::ST_IDLE && !do_start)
    |=> s_q.st == irpm_pkg::ST_IDLE)
    else $error("sequencer left idle without a start");

  flag_clear_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (clr_int && !finish) |=> !s_q.flag)
    else $error("interrupt flag not cleared");

  clr_pulse_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_q.wd_clr |=> !s_q.wd_clr)
    else $error("watchdog clear bit was stored");

endmodule // irpm_top

/* File: logic/irpm_pkg.sv */
// constants and types shared by the infrared pulse modulator block
// Operation
// - pulse count low write starts modulator
// - load on-time, count timer down each cycle
// - on-time expiry decrements count, output goes high
// - off-time loaded; expiry drives output low again
// - count zero raises interrupt flag, halts
// - flag blocks restart; cleared by writing one
// - watchdog: 17-bit, steps every 30 cycles
// - power-on reset clears watchdog count
// - watchdog overflow resets the controller
// - watchdog clear bit clears count, stores nothing
// - overflow after 30 times 2^16 cycles
// - idle mode: watchdog keeps counting
// - stop mode: watchdog holds its count
// - pin drive type and reset level build-time
// - each phase lasts value plus two cycles
// - continuous bit without long bit: endless train
// - long bit: one pulse, off-time ignored
// - carrier bit modulates active phase at fosc/4
package irpm_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // register indices; the byte address is four times the index
  localparam logic [3:0] IDX_ON_TIME = 4'h0;
  localparam logic [3:0] IDX_OFF_TIME = 4'h1;
  localparam logic [3:0] IDX_PUL_LO = 4'h2;
  localparam logic [3:0] IDX_CTRL = 4'h3;
  localparam logic [3:0] IDX_PUL_HI = 4'h4;
  localparam logic [3:0] IDX_STATUS = 4'h5;
  localparam logic [3:0] IDX_WD_COUNT = 4'h6;
  localparam logic [3:0] IDX_LAST = 4'h6;

  // modulator_control_reg fields
  localparam int unsigned CTRL_WDCLR_BIT = 4;
  localparam int unsigned CTRL_INTCLR_BIT = 3;
  localparam int unsigned CTRL_CONT_BIT = 2;
  localparam int unsigned CTRL_LONG_BIT = 1;
  localparam int unsigned CTRL_CARRIER_BIT = 0;

  // status register fields
  localparam int unsigned STAT_FLAG_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [9:0] CNT_ONE = 10'h001;
  localparam logic [8:0] TIMER_ONE = 9'h001;
  localparam logic [8:0] PHASE_EXTRA = 9'h001;

  // watchdog: step every 30 cycles, trip when the count reaches 2^16
  localparam int unsigned WD_W = 17;
  localparam int unsigned WD_PRE_W = 5;
  localparam logic [4:0] WD_PRE_LAST = 5'h1d;
  localparam logic [16:0] WD_LIMIT = 17'h10000;

  localparam int unsigned CAR_W = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ON = 2'h1,
    ST_OFF = 2'h3
  } irpm_state_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } irpm_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } irpm_axil_rsp_t;

endpackage

/* File: logic/irpm_wdog.sv */
// watchdog counter with prescaler and overflow reset pulse
`timescale 1ns/10ps
module irpm_wdog #(
  parameter logic [16:0] LIMIT = irpm_pkg::WD_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic halt_i,
  output logic [irpm_pkg::WD_W-1:0] count_o,
  output logic trip_o
);

  typedef struct packed {
    logic [irpm_pkg::WD_PRE_W-1:0] pre;
    logic [irpm_pkg::WD_W-1:0] cnt;
    logic trip;
  } irpm_wd_st_t;

  irpm_wd_st_t s_q;
  irpm_wd_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.trip = 1'b0;
    if (clear_i) begin
      s_d.pre = '0;
      s_d.cnt = '0;
    end else if (!halt_i) begin
      if (s_q.pre == irpm_pkg::WD_PRE_LAST) begin
        s_d.pre = '0;
        if (s_q.cnt + 17'h00001 == LIMIT) begin
          s_d.cnt = '0;
          s_d.trip = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 17'h00001;
        end
      end else begin
        s_d.pre = s_q.pre + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.cnt;
  assign trip_o = s_q.trip;

  wd_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i |=> (s_q.cnt == '0 && !s_q.trip))
    else $error("watchdog not cleared");

  wd_stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (halt_i && !clear_i) |=> $stable(s_q.cnt) && $stable(s_q.pre))
    else $error("watchdog moved in stop mode");

  wd_trip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!halt_i && !clear_i && s_q.pre == irpm_pkg::WD_PRE_LAST &&
     s_q.cnt == LIMIT - 17'h00001) |=> (s_q.trip ##1 !s_q.trip))
    else $error("watchdog overflow pulse wrong");

endmodule // irpm_wdog

/* File: logic/irpm_pin.sv */
// output stage: carrier gating and build-time drive type of the pulse pin
`timescale 1ns/10ps
module irpm_pin #(
  parameter bit OPEN_DRAIN = 1'b1,
  parameter bit RESET_LOW = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic active_i,
  input wire logic carrier_i,
  output logic pin_o,
  output logic oe_o
);

  typedef struct packed {
    logic [irpm_pkg::CAR_W-1:0] car;
    logic hold_low;
    logic low;
    logic pin;
    logic oe;
  } irpm_pin_st_t;

  irpm_pin_st_t s_q;
  irpm_pin_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.car = active_i ? s_q.car + 2'h1 : '0;
    // reset level stands only until the first train begins
    s_d.hold_low = s_q.hold_low & !active_i;
    if (active_i) begin
      s_d.low = !(carrier_i && s_q.car[irpm_pkg::CAR_W-1]);
    end else begin
      s_d.low = s_d.hold_low;
    end
    s_d.pin = OPEN_DRAIN ? 1'b0 : !s_d.low;
    s_d.oe = OPEN_DRAIN ? s_d.low : 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.car <= '0;
      s_q.hold_low <= RESET_LOW;
      s_q.low <= RESET_LOW;
      s_q.pin <= OPEN_DRAIN ? 1'b0 : !RESET_LOW;
      s_q.oe <= OPEN_DRAIN ? RESET_LOW : 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_o = s_q.pin;
  assign oe_o = s_q.oe;

  carrier_period_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (active_i && carrier_i && s_q.car == 2'h2) |=> !s_q.low)
    else $error("carrier high quarter missing");

endmodule // irpm_pin

/* File: testbench/irpm_led.sv */
// infrared led model standing on the pulse pin
`timescale 1ns/10ps
module irpm_led #(
  parameter bit OPEN_DRAIN = 1'b1
) (
  input wire logic pin_i,
  input wire logic oe_i,
  output logic lit_o
);
  logic line;
  // open-drain build relies on the pull-up of the led supply when released
  assign line = OPEN_DRAIN ? (oe_i === 1'b1 ? pin_i : 1'b1) : pin_i;
  // the led conducts only while the line is pulled low; unknown counts as dark
  assign lit_o = (line === 1'b0);
endmodule // irpm_led

/* File: testbench/irpm_top_tb.sv */
// self-checking bench for the pulse modulator and watchdog
`timescale 1ns/10ps
module irpm_top_tb;
  localparam logic [16:0] WD_LIM = 17'h00004;
  localparam int WD_PERIOD = 120;
  logic clk;
  logic rst;
  logic stop_mode;
  irpm_pkg::irpm_axil_req_t req;
  irpm_pkg::irpm_axil_rsp_t rsp;
  logic pin;
  logic oe;
  logic irq;
  logic wd_trip;
  logic lit;
  int n_errors = 0;
  int compares = 0;
  int runs[$];
  int run_len = 0;
  logic run_lvl = 1'b0;

  irpm_top #(.WD_LIMIT(WD_LIM), .OPEN_DRAIN(1'b1),
    .RESET_LOW(1'b0)) i_irpm_top (
    .CLOCK_I(clk),
    .RST_I(rst),
    .STOP_MODE_I(stop_mode),
    .S_AXI_I(req),
    .S_AXI_O(rsp),
    .IR_PULSE_OUT_O(pin),
    .IR_PULSE_OE_O(oe),
    .MODULATOR_IRQ_REQUEST_O(irq),
    .WDOG_RESET_O(wd_trip)
  );

  irpm_led #(.OPEN_DRAIN(1'b1)) i_irpm_led (
    .pin_i(pin),
    .oe_i(oe),
    .lit_o(lit)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // run lengths of the light, encoded as level * 65536 + cycles
  always @(posedge clk) begin
    if (lit === run_lvl) run_len++;
    else begin
      runs.push_back(run_lvl * 65536 + run_len);
      run_lvl = lit;
      run_len = 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [7:0] adr(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // bready and rready stay high, so only the request channels are released
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    do begin
      @(posedge clk);
      n++;
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      got = rsp.bvalid === 1'b1;
      r = rsp.bresp;
    end while (!got && n < 50);
    if (!got) n_errors++;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge clk);
      n++;
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      got = rsp.rvalid === 1'b1;
      d = rsp.rdata;
      r = rsp.rresp;
    end while (!got && n < 50);
    if (!got) n_errors++;
  endtask

  task automatic wait_trip(output int gap);
    gap = 0;
    do begin
      @(posedge clk);
      gap++;
    end while (wd_trip !== 1'b1 && gap < 1000);
  endtask

  task automatic run_train(input int on_t, input int off_t, input int cnt,
                           input logic [2:0] mode);
    int lvl[$];
    int ex[$];
    int len;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    len = mode[1] ? (on_t + 2) * cnt : on_t + 2;
    for (int p = 0; p < (mode[1] ? 1 : cnt); p++) begin
      for (int k = 0; k < len; k++)
        lvl.push_back(mode[0] ? int'(k % 4 < 2) : 1);
      if (!mode[1] && p < cnt - 1)
        for (int k = 0; k < off_t + 2; k++) lvl.push_back(0);
    end
    n = 1;
    for (int k = 1; k <= lvl.size(); k++)
      if (k < lvl.size() && lvl[k] == lvl[k - 1]) n++;
      else begin
        ex.push_back(lvl[k - 1] * 65536 + n);
        n = 1;
      end
    // the trailing dark run never ends, so it is never recorded
    if (lvl[lvl.size() - 1] == 0) void'(ex.pop_back());
    axi_write(adr(irpm_pkg::IDX_PUL_HI), 32'(cnt >> 8), r);
    axi_write(adr(irpm_pkg::IDX_CTRL), {29'h0, mode}, r);
    axi_write(adr(irpm_pkg::IDX_ON_TIME), 32'(on_t), r);
    axi_write(adr(irpm_pkg::IDX_OFF_TIME), 32'(off_t), r);
    runs.delete();
    axi_write(adr(irpm_pkg::IDX_PUL_LO), 32'(cnt & 255), r);
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    check(runs.size(), ex.size() + 1);
    for (int i = 0; i < ex.size() && i + 1 < runs.size(); i++)
      check(runs[i + 1], ex[i]);
    axi_read(adr(irpm_pkg::IDX_STATUS), d, r);
    check(d, 32'h1);
    runs.delete();
    axi_write(adr(irpm_pkg::IDX_PUL_LO), 32'h1, r);
    repeat (20) @(posedge clk);
    check(runs.size(), 0);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h8, r);
    check(irq, 1'b0);
  endtask

  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    int gap;
    int n;
    logic [2:0] modes [4];
    modes = '{3'h0, 3'h0, 3'h1, 3'h2};
    rst = 1'b1;
    stop_mode = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    void'($urandom(40078));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(lit, 1'b0);
    for (int i = 0; i < 7; i++) begin
      axi_read(adr(4'(i)), d, r);
      check(d, 32'h0);
    end
    axi_write(adr(irpm_pkg::IDX_ON_TIME), 32'hffffff5a, r);
    axi_read(adr(irpm_pkg::IDX_ON_TIME), d, r);
    check(d, 32'h5a);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h1f, r);
    axi_read(adr(irpm_pkg::IDX_CTRL), d, r);
    check(d, 32'h7);
    axi_write(8'h1c, 32'h1, r);
    check(r, irpm_pkg::RESP_SLVERR);
    axi_read(8'h1c, d, r);
    check(r, irpm_pkg::RESP_SLVERR);
    check(d, 32'h0);
    axi_write(adr(irpm_pkg::IDX_STATUS), 32'h3, r);
    axi_read(adr(irpm_pkg::IDX_STATUS), d, r);
    check(d, 32'h0);
    // first train spans both count registers
    for (int t = 0; t < 4; t++)
      run_train($urandom % 8, $urandom % 8,
                t == 0 ? 257 : $urandom % 4 + 1, modes[t]);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h4, r);
    axi_write(adr(irpm_pkg::IDX_PUL_LO), 32'h2, r);
    repeat (300) @(posedge clk);
    check(irq, 1'b0);
    axi_read(adr(irpm_pkg::IDX_PUL_LO), d, r);
    check(d, 32'h2);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h0, r);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(irq, 1'b1);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h8, r);
    wait_trip(gap);
    wait_trip(gap);
    check(gap, WD_PERIOD);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h10, r);
    axi_read(adr(irpm_pkg::IDX_WD_COUNT), d, r);
    check(d, 32'h0);
    wait_trip(gap);
    check(gap > 105 && gap < WD_PERIOD, 1'b1);
    axi_write(adr(irpm_pkg::IDX_CTRL), 32'h10, r);
    repeat (40) @(posedge clk);
    stop_mode <= 1'b1;
    axi_read(adr(irpm_pkg::IDX_WD_COUNT), d, r);
    check(d, 32'h1);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      if (wd_trip === 1'b1) n++;
    end
    check(n, 0);
    axi_read(adr(irpm_pkg::IDX_WD_COUNT), d, r);
    check(d, 32'h1);
    stop_mode <= 1'b0;
    wait_trip(gap);
    check(gap > 60 && gap < 90, 1'b1);
    stop_test();
  end

  initial begin
    #4_000_000;
    n_errors++;
    stop_test();
  end
endmodule // irpm_top_tb
